// ==== logic/pfwm_mapper.sv ====
/*
  fabric word mapper for one lane: places transmit words from the mac
  onto the coding sublayer beat by beat, and gathers decoded receive
  symbols into the 64-bit receive bus; mode and status over apb.
  assumes one clock, symbols delivered every clock, apb master in the
  same domain, and mac inputs synchronous to clk.
*/
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - single, no serializer: tx bits 10:0
// - single, serializer: tx 32:22 and 10:0
// - double, no serializer: tx bits 21:0
// - double, serializer: tx bits 43:0
// - serializer halves word rate, doubles width
// - receive words are a streaming source
// - receive words valid every receive clock
// - decoded byte 7:0, control flag bit 8
// - bit 9 code violation, bit 10 alignment
// - bit 11 disparity error, bit 12 pattern
// - bits 14:13 rate match, underflow values
// - no decoder, no reconfig: fabric width
// - bypass with reconfig: raw group 9:0
// - bypass with reconfig: bit 10 sync, 11-14 kept
// - bypass with reconfig: bit 15 running disparity
// - receive clock output, words synchronous
// - rx words at 15:0, 47:32, 31:0, 63:0
// - transmit words taken with no backpressure
module pfwm_mapper #(
  parameter int unsigned TX_BUS_W = 44,  // transmit bus width
  parameter int unsigned RX_BUS_W = 64   // receive bus width
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire pfwm_pkg::pfwm_apbreq_t apbReq,
  output var  pfwm_pkg::pfwm_apbrsp_t apbRsp,
  input  wire logic [TX_BUS_W-1:0]   txData,
  output logic                       txClkEn,
  output var  pfwm_pkg::pfwm_pmatx_t  pmaTx,
  input  wire pfwm_pkg::pfwm_sym_t    pmaSym0,
  input  wire pfwm_pkg::pfwm_sym_t    pmaSym1,
  output logic [RX_BUS_W-1:0]        rxData,
  output logic                       rxClkEn
);
  import pfwm_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (TX_BUS_W != 4 * TXW) begin : g_txw_chk
    $error("transmit bus must hold four words");
  end
  if (RX_BUS_W != 4 * RXW) begin : g_rxw_chk
    $error("receive bus must hold four words");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                phase;   // serializer beat
    pfwm_mode_t          mode;    // software mode
    logic [3:0]          sticky;  // receive events
    logic [RX_BUS_W-1:0] rxBus;   // receive bus
    logic [2*RXW-1:0]    rxLow;   // first beat words
    logic                rxStb;   // new receive words
    pfwm_pmatx_t         tx;      // beat to coder
    logic [2*TXW-1:0]    txHold;  // second beat words
    logic [31:0]         prdata;  // read data
    logic                pslverr; // unmapped address
  } pfwm_st_t;

  pfwm_st_t state;       // registered copy
  pfwm_st_t next_state;  // next value

  // ----------------------------------------------------------------
  // receive word formation
  // ----------------------------------------------------------------
  logic [RXW-1:0] rxWord0;   // word from symbol 0
  logic [RXW-1:0] rxWord1;   // word from symbol 1
  logic           ufl0;      // symbol 0 underflow
  logic           ufl1;      // symbol 1 underflow

  pfwm_rx_pack u_pack0 (
    .sym       (pmaSym0),
    .mode      (state.mode),
    .word      (rxWord0),
    .underflow (ufl0)
  );

  pfwm_rx_pack u_pack1 (
    .sym       (pmaSym1),
    .mode      (state.mode),
    .word      (rxWord1),
    .underflow (ufl1)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setupRd;  // setup phase of any transfer
  logic ctrlWr;   // control write takes effect
  logic statWr;   // status clear takes effect
  logic mapped;   // address hits a register

  always_comb begin
    setupRd = apbReq.psel && !apbReq.penable;
    ctrlWr  = apbReq.psel && apbReq.penable && apbReq.pwrite &&
              (apbReq.paddr == CTRL_OFS);
    statWr  = apbReq.psel && apbReq.penable && apbReq.pwrite &&
              (apbReq.paddr == STAT_OFS);
    mapped  = (apbReq.paddr == CTRL_OFS) || (apbReq.paddr == STAT_OFS) ||
              (apbReq.paddr == RXW_OFS)  || (apbReq.paddr == TXW_OFS);
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // upper bits unused for raw words under reconfiguration
  function automatic logic [TXW-1:0] fixTx(
    input logic [TXW-1:0] w,
    input pfwm_mode_t     m
  );
    logic [TXW-1:0] r;
    r = w;
    if (!m.decEn && m.dynRecfg) begin
      r = {3'h0, w[7:0]};
    end
    return r;
  endfunction : fixTx

  logic [3:0] rxEvt;   // events seen this clock
  logic       doubleW; // double-word bus

  always_comb begin
    doubleW = state.mode.dblWord;
    rxEvt   = 4'h0;
    if (state.mode.decEn) begin
      rxEvt[ST_CERR] = pmaSym0.codeErr || (doubleW && pmaSym1.codeErr);
    end
    rxEvt[ST_DERR] = pmaSym0.dispErr || (doubleW && pmaSym1.dispErr);
    rxEvt[ST_UFL]  = ufl0 || (doubleW && ufl1);
    rxEvt[ST_OFL]  = (pmaSym0.rm == RM_OVF) ||
                     (doubleW && (pmaSym1.rm == RM_OVF));
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    // transmit words sampled on every beat that is not a second half
    txClkEn = !state.mode.serEn || !state.phase;

    // serializer beat toggles only with the serializer on
    next_state.phase = state.mode.serEn ? !state.phase : 1'b0;

    // ---- transmit placement ----
    if (txClkEn) begin
      // first beat: words 0 and 1
      next_state.tx.w0   = fixTx(txData[TXW-1:0], state.mode);
      next_state.tx.w1   = doubleW ?
                           fixTx(txData[2*TXW-1:TXW], state.mode) :
                           '0;
      next_state.tx.mask = {doubleW, 1'b1};
      // words 2 and 3 wait for the second beat
      next_state.txHold[TXW-1:0] =
        fixTx(txData[3*TXW-1:2*TXW], state.mode);
      next_state.txHold[2*TXW-1:TXW] = doubleW ?
        fixTx(txData[4*TXW-1:3*TXW], state.mode) : '0;
    end else begin
      // second beat from the hold register
      next_state.tx.w0   = state.txHold[TXW-1:0];
      next_state.tx.w1   = state.txHold[2*TXW-1:TXW];
      next_state.tx.mask = {doubleW, 1'b1};
    end

    // ---- receive placement ----
    next_state.rxStb = !state.mode.serEn || state.phase;
    if (!state.mode.serEn) begin
      // one beat makes the whole word set
      next_state.rxBus = {32'h0000_0000,
                          doubleW ? rxWord1 : 16'h0000,
                          rxWord0};
    end else if (!state.phase) begin
      // first beat parked as words 0 and 1
      next_state.rxLow = {doubleW ? rxWord1 : 16'h0000, rxWord0};
    end else begin
      // second beat lands as words 2 and 3
      next_state.rxBus = {doubleW ? rxWord1 : 16'h0000,
                          rxWord0, state.rxLow};
    end

    // ---- sticky events, set beats clear ----
    next_state.sticky = state.sticky;
    if (statWr) begin
      next_state.sticky = state.sticky & ~apbReq.pwdata[3:0];
    end
    next_state.sticky = next_state.sticky | rxEvt;

    // ---- control write ----
    if (ctrlWr) begin
      next_state.mode  = apbReq.pwdata[3:0];
      next_state.phase = 1'b0;  // restart on a clean beat
    end

    // ---- read data captured in setup ----
    if (setupRd) begin
      next_state.pslverr = !mapped;
      case (apbReq.paddr)
        CTRL_OFS: next_state.prdata = {28'h0, state.mode};
        STAT_OFS: next_state.prdata = {28'h0, state.sticky};
        RXW_OFS:  next_state.prdata = {16'h0, state.rxBus[RXW-1:0]};
        TXW_OFS:  next_state.prdata = {21'h0, state.tx.w0};
        default:  next_state.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state        <= '0;
      state.mode   <= CTRL_RST;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    rxData         = state.rxBus;   // valid each clock that rxClkEn is high
    rxClkEn        = state.rxStb;   // receive clock as enable
    pmaTx          = state.tx;
    apbRsp.prdata  = state.prdata;
    apbRsp.pslverr = state.pslverr;
    apbRsp.pready  = 1'b1;          // zero wait states
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_tx_single;
    @(posedge clk) disable iff (!rstn)
    (txClkEn && !state.mode.serEn && !doubleW && !ctrlWr)
      |=> (pmaTx.mask == 2'b01) && (pmaTx.w1 == '0) &&
          (pmaTx.w0 == fixTx($past(txData[10:0]), state.mode));
  endproperty
  a_tx_single: assert property (p_tx_single)
    else $error("single-word transmit placement wrong");

  property p_tx_ser_single;
    @(posedge clk) disable iff (!rstn)
    (txClkEn && state.mode.serEn && !doubleW && !ctrlWr) ##1 !ctrlWr
      |=> pmaTx.w0 == fixTx($past(txData[32:22], 2), state.mode);
  endproperty
  a_tx_ser_single: assert property (p_tx_ser_single)
    else $error("word 2 missing on second beat");

  property p_tx_dbl;
    @(posedge clk) disable iff (!rstn)
    (txClkEn && !state.mode.serEn && doubleW && !ctrlWr)
      |=> (pmaTx.mask == 2'b11) &&
          (pmaTx.w1 == fixTx($past(txData[21:11]), state.mode));
  endproperty
  a_tx_dbl: assert property (p_tx_dbl)
    else $error("word 1 placement wrong");

  property p_tx_dbl_ser;
    @(posedge clk) disable iff (!rstn)
    (txClkEn && state.mode.serEn && doubleW && !ctrlWr) ##1 !ctrlWr
      |=> pmaTx.w1 == fixTx($past(txData[43:33], 2), state.mode);
  endproperty
  a_tx_dbl_ser: assert property (p_tx_dbl_ser)
    else $error("word 3 missing on second beat");

  property p_half_rate;
    @(posedge clk) disable iff (!rstn)
    (state.mode.serEn && txClkEn && !ctrlWr) |=> !txClkEn ##1 txClkEn;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("serializer beat rate wrong");

  property p_no_stall;
    @(posedge clk) disable iff (!rstn)
    !state.mode.serEn |-> txClkEn;
  endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("transmit stalled");

  property p_rx_every;
    @(posedge clk) disable iff (!rstn)
    (!state.mode.serEn && !ctrlWr) |=> rxClkEn;
  endproperty
  a_rx_every: assert property (p_rx_every)
    else $error("receive word not presented");

  property p_rx_place;
    @(posedge clk) disable iff (!rstn)
    (rxClkEn && !doubleW && !$past(ctrlWr) && !$past(ctrlWr, 2))
      |-> (rxData[31:16] == '0) && (rxData[63:48] == '0);
  endproperty
  a_rx_place: assert property (p_rx_place)
    else $error("unused receive words not zero");

  property p_rx_dec;
    @(posedge clk) disable iff (!rstn)
    (!state.mode.serEn && state.mode.decEn && !ctrlWr)
      |=> rxData[8:0] == $past({pmaSym0.ctl, pmaSym0.data});
  endproperty
  a_rx_dec: assert property (p_rx_dec)
    else $error("decoded byte or flag misplaced");

  property p_rx_rd;
    @(posedge clk) disable iff (!rstn)
    (!state.mode.serEn && state.mode.decEn && !ctrlWr)
      |=> rxData[15] == $past(pmaSym0.runDisp);
  endproperty
  a_rx_rd: assert property (p_rx_rd)
    else $error("running disparity not in bit 15");

  property p_ufl;
    @(posedge clk) disable iff (!rstn)
    ufl0 |=> state.sticky[ST_UFL] ##1 (state.sticky[ST_UFL] || $past(statWr));
  endproperty
  a_ufl: assert property (p_ufl)
    else $error("underflow not held");

endmodule : pfwm_mapper

`default_nettype wire

// ==== logic/pfwm_pkg.sv ====
/*
  constants, field layouts and carrier types of the fabric word mapper.
  assumes nothing of its surroundings; compiled before every module.
*/
`default_nettype none

package pfwm_pkg;

  // ----------------------------------------------------------------
  // word and bus widths
  // ----------------------------------------------------------------
  localparam int unsigned TXW      = 11;  // transmit word width
  localparam int unsigned RXW      = 16;  // receive word width
  localparam int unsigned RAWW     = 10;  // raw code group width
  localparam int unsigned TXBUS_W  = 44;  // four transmit words
  localparam int unsigned RXBUS_W  = 64;  // four receive words

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;  // mode control
  localparam logic [11:0] STAT_OFS = 12'h004;  // sticky receive events
  localparam logic [11:0] RXW_OFS  = 12'h008;  // receive word 0 now
  localparam logic [11:0] TXW_OFS  = 12'h00C;  // transmit word 0 now

  // control bits and value after reset (decoder on)
  localparam int unsigned CTRL_SER = 0;
  localparam int unsigned CTRL_DBL = 1;
  localparam int unsigned CTRL_DEC = 2;
  localparam int unsigned CTRL_DRC = 3;
  localparam logic [3:0]  CTRL_RST = 4'h4;

  // status bits, write one to clear
  localparam int unsigned ST_CERR = 0;
  localparam int unsigned ST_DERR = 1;
  localparam int unsigned ST_UFL  = 2;
  localparam int unsigned ST_OFL  = 3;

  // ----------------------------------------------------------------
  // receive word fields
  // ----------------------------------------------------------------
  localparam int unsigned RXF_CTL  = 8;
  localparam int unsigned RXF_CERR = 9;
  localparam int unsigned RXF_ALN  = 10;
  localparam int unsigned RXF_DERR = 11;
  localparam int unsigned RXF_PAT  = 12;
  localparam int unsigned RXF_RM   = 13;  // low bit of two
  localparam int unsigned RXF_RD   = 15;

  // rate-match codes and underflow data values
  localparam logic [1:0] RM_NORM = 2'h0;
  localparam logic [1:0] RM_DEL  = 2'h1;
  localparam logic [1:0] RM_INS  = 2'h2;
  localparam logic [1:0] RM_OVF  = 2'h3;
  localparam logic [8:0] UFL_V1  = 9'h1FE;
  localparam logic [8:0] UFL_V2  = 9'h1F7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [RAWW-1:0] raw;      // undecoded code group
    logic [7:0]      data;     // decoded byte
    logic            ctl;      // control character
    logic            codeErr;  // code violation
    logic            aligned;  // alignment or sync status
    logic            dispErr;  // disparity error
    logic            patDet;   // alignment pattern seen
    logic [1:0]      rm;       // rate-match status
    logic            runDisp;  // running disparity
  } pfwm_sym_t;

  typedef struct packed {
    logic dynRecfg;
    logic decEn;
    logic dblWord;
    logic serEn;
  } pfwm_mode_t;

  typedef struct packed {
    logic [1:0]     mask;  // valid words
    logic [TXW-1:0] w1;
    logic [TXW-1:0] w0;
  } pfwm_pmatx_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pfwm_apbreq_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pfwm_apbrsp_t;

endpackage : pfwm_pkg

`default_nettype wire

// ==== logic/pfwm_rx_pack.sv ====
/*
  forms one 16-bit receive word from one decoded symbol.
  assumes the mode bits are stable around the sampling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pfwm_rx_pack (
  input  wire pfwm_pkg::pfwm_sym_t  sym,
  input  wire pfwm_pkg::pfwm_mode_t mode,
  output logic [15:0]               word,
  output logic                      underflow
);
  import pfwm_pkg::*;

  // ----------------------------------------------------------------
  // field mapping
  // ----------------------------------------------------------------
  always_comb begin
    word = 16'h0000;
    if (mode.decEn) begin
      // decoded byte and control flag
      word[7:0]      = sym.data;
      word[RXF_CTL]  = sym.ctl;
      word[RXF_CERR] = sym.codeErr;
      word[RXF_ALN]  = sym.aligned;
    end else if (mode.dynRecfg) begin
      // raw group plus sync status
      word[RAWW-1:0] = sym.raw;
      word[RXF_ALN]  = sym.aligned;
    end else begin
      // plain fabric width, nothing else
      word[RAWW-1:0] = sym.raw;
    end
    if (mode.decEn || mode.dynRecfg) begin
      word[RXF_DERR]       = sym.dispErr;
      word[RXF_PAT]        = sym.patDet;
      word[RXF_RM+1:RXF_RM] = sym.rm;
      word[RXF_RD]         = sym.runDisp;
    end
  end

  // insertion code read as underflow on the two fill values
  always_comb begin
    underflow = (sym.rm == RM_INS) &&
                (({sym.ctl, sym.data} == UFL_V1) ||
                 ({sym.ctl, sym.data} == UFL_V2));
  end

endmodule : pfwm_rx_pack

`default_nettype wire

// ==== bench/pfwm_mac_model.sv ====
/*
  mac model beside the fabric word mapper: feeds transmit words and
  takes every receive bus that the mapper flags.
  assumes the mapper's clk and rstn, no other clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pfwm_mac_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        txClkEn,
  input  wire logic        rxClkEn,
  input  wire logic [63:0] rxData,
  output logic      [43:0] txData,
  output logic      [63:0] rxLast
);
  logic [7:0] cnt;  // words sent so far

  // one transmit word: disparity, force, control, byte
  function automatic logic [10:0] mk(input logic [7:0] c);
    return {c[1], 1'h0, c[0], c};
  endfunction : mk

  // ------------------------------------------------
  // transmit side
  // ------------------------------------------------
  // fresh words only once the mapper took the last ones
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt    <= 8'h00;
      txData <= 44'h000_0000_0000;
    end else if (txClkEn) begin
      cnt    <= cnt + 8'h04;
      txData <= {mk(cnt + 8'h03), mk(cnt + 8'h02), mk(cnt + 8'h01), mk(cnt)};
    end
  end

  // ------------------------------------------------
  // receive side
  // ------------------------------------------------
  // no stall possible, every flagged bus is kept
  always @(posedge clk or negedge rstn) begin
    if (!rstn) rxLast <= 64'h0;
    else if (rxClkEn) rxLast <= rxData;
  end
endmodule : pfwm_mac_model

`default_nettype wire

// ==== bench/tb_pfwm_mapper.sv ====
/*
  self-checking bench of the fabric word mapper: apb tasks, a sweep
  of six modes, sticky status events.
  assumes the package and the mac model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_pfwm_mapper;
  import pfwm_pkg::*;

  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic         clk = 1'h0;       // 125 MHz
  logic         rstn = 1'h0;      // reset, active low
  pfwm_apbreq_t apbReq = '0;      // apb request
  pfwm_apbrsp_t apbRsp;           // apb answer
  logic [43:0]  txData;           // mac transmit bus
  logic         txClkEn;          // transmit words taken
  pfwm_pmatx_t  pmaTx;            // words toward coder
  pfwm_sym_t    sym0 = '0;        // decoded symbol, word 0
  pfwm_sym_t    sym1 = '0;        // decoded symbol, word 1
  logic [63:0]  rxData;           // receive bus
  logic         rxClkEn;          // receive bus updated
  logic [63:0]  rxLast;           // last bus the mac took
  int           errors = 0;       // mismatches
  int           cmpCount = 0;     // comparisons
  logic [31:0]  rdv;              // last read data
  logic         rde;              // last read error
  logic [3:0]   modes [6] = '{4'h4, 4'h8, 4'h0, 4'h6, 4'h5, 4'h7};
  logic [1:0]   rmv [4] = '{2'h2, 2'h2, 2'h2, 2'h3};
  logic [8:0]   cdv [4] = '{9'h1FE, 9'h1F7, 9'h1FD, 9'h000};
  logic [3:0]   stv [4] = '{4'h4, 4'h4, 4'h0, 4'hB};

  always #4 clk = ~clk;

  pfwm_mapper pfwm_mapper_i (.clk(clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
    .txData(txData), .txClkEn(txClkEn), .pmaTx(pmaTx), .pmaSym0(sym0), .pmaSym1(sym1),
    .rxData(rxData), .rxClkEn(rxClkEn));

  pfwm_mac_model pfwm_mac_model_i (.clk(clk), .rstn(rstn), .txClkEn(txClkEn),
    .rxClkEn(rxClkEn), .rxData(rxData), .txData(txData), .rxLast(rxLast));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  // symbol with every field moved by k
  function automatic pfwm_sym_t ms(input logic [3:0] k);
    return '{raw: {k, 6'h25}, data: {k, 4'h9}, ctl: k[0], codeErr: k[1], aligned: ~k[0],
             dispErr: k[2], patDet: ~k[1], rm: k[1:0], runDisp: k[3]};
  endfunction : ms

  // receive word expected in mode c
  function automatic logic [15:0] exw(input pfwm_sym_t s, input logic [3:0] c);
    if (c[CTRL_DEC]) return {s.runDisp, s.rm, s.patDet, s.dispErr, s.aligned, s.codeErr,
                             s.ctl, s.data};
    if (c[CTRL_DRC]) return {s.runDisp, s.rm, s.patDet, s.dispErr, s.aligned, s.raw};
    return {6'h00, s.raw};
  endfunction : exw

  // transmit word expected toward coder
  function automatic logic [10:0] fx(input logic [10:0] w, input logic [3:0] c);
    return (!c[CTRL_DEC] && c[CTRL_DRC]) ? {3'h0, w[7:0]} : w;
  endfunction : fx

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'h1;
    // pready ends this wait, the watchdog only if it never comes
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'h1);
    rdv = apbRsp.prdata;
    rde = apbRsp.pslverr;
    apbReq.psel    <= 1'h0;
    apbReq.penable <= 1'h0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    apb(1'h0, a, 32'h0);
    chk(rdv, exp);
    chk(rde, ee);
  endtask : rdc

  task automatic completeRun;
    if (errors == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : completeRun

  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    logic [43:0] d;
    logic [3:0]  m;
    int          n;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rdc(CTRL_OFS, {28'h0, CTRL_RST}, 1'h0);
    rdc(12'h010, 32'h0, 1'h1);
    apb(1'h1, 12'h010, 32'hF);
    rdc(CTRL_OFS, 32'h4, 1'h0);
    // six modes: receive fields, word places, beat rate
    foreach (modes[i]) begin
      m = modes[i];
      apb(1'h1, CTRL_OFS, {28'h0, m});
      rdc(CTRL_OFS, {28'h0, m}, 1'h0);
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        sym0 <= ms(4'(k));
        sym1 <= ms(~4'(k));
        repeat (6) @(posedge clk);
        #1;
        chk(rxLast[15:0], exw(sym0, m));
        if (m[CTRL_DBL]) chk(rxLast[31:16], exw(sym1, m));
        if (m[CTRL_SER]) chk(rxLast[47:32], exw(sym0, m));
        if (m[CTRL_SER] && m[CTRL_DBL]) chk(rxLast[63:48], exw(sym1, m));
        n = 0;
        repeat (8) begin
          @(posedge clk);
          #1;
          n += (rxClkEn === 1'h1);
        end
        chk(n, m[CTRL_SER] ? 4 : 8);
        // transmit beat from the words taken at one edge
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (txClkEn !== 1'h1 && n < 4);
        chk(txClkEn, 1'h1);
        d = txData;
        @(posedge clk);
        #1;
        chk(pmaTx.w0, fx(d[10:0], m));
        chk(pmaTx.mask, {m[CTRL_DBL], 1'h1});
        if (m[CTRL_DBL]) chk(pmaTx.w1, fx(d[21:11], m));
        chk(txClkEn, !m[CTRL_SER]);
        if (m[CTRL_SER]) begin
          @(posedge clk);
          #1;
          chk(pmaTx.w0, fx(d[32:22], m));
          if (m[CTRL_DBL]) chk(pmaTx.w1, fx(d[43:33], m));
        end
      end
      if (!m[CTRL_SER]) rdc(RXW_OFS, {16'h0, exw(sym0, m)}, 1'h0);
    end
    // sticky events: underflow values, insertion, overflow, errors
    apb(1'h1, CTRL_OFS, 32'h4);
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      sym0 <= '0;
      repeat (3) @(posedge clk);
      apb(1'h1, STAT_OFS, 32'hF);
      rdc(STAT_OFS, 32'h0, 1'h0);
      @(posedge clk);
      sym0 <= '{rm: rmv[j], ctl: cdv[j][8], data: cdv[j][7:0], codeErr: j == 3,
                dispErr: j == 3, default: '0};
      @(posedge clk);
      sym0 <= '0;
      repeat (3) @(posedge clk);
      rdc(STAT_OFS, {28'h0, stv[j]}, 1'h0);
    end
    completeRun();
  end

  // hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #50000;
    errors++;
    completeRun();
  end
endmodule : tb_pfwm_mapper

`default_nettype wire
